// ===== src/adcrm_top.sv
// Converter result and mode control: Wishbone slave, sequencer, interrupt.
// Assumes an analog core that takes a channel request and returns a value
// with a one-cycle done pulse; DMA acknowledge is a one-cycle pulse.
`timescale 1ns/10ps
`include "adcrm_cfg.svh"
module adcrm_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic standby,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output adcrm_pkg::adcrm_conv_req_t conv_req,
  input wire adcrm_pkg::adcrm_conv_rsp_t conv_rsp,
  input wire logic dma_ack,
  output logic unit0_conversion_irq
);
  import adcrm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_WAIT = 3'b100
  } adcrm_st_t;

  typedef struct packed {
    adcrm_csr_t csr;
    logic start;
    logic scan_cont;
    logic flag_seen;
    adcrm_st_t st;
    logic [3:0] cur;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } adcrm_state_t;

  adcrm_state_t q;
  adcrm_state_t next_q;
  logic [3:0] plan_first;
  logic [3:0] plan_next;
  logic plan_last;
  logic [15:0] bank_data;
  logic bank_wr;
  logic hit_res;
  logic hit_csr;
  logic hit_ctrl;
  logic req;
  logic wr_lane0;

  // ==========================================================
  // Helpers
  adcrm_chan_plan u_plan (
    .mode(q.csr.mode),
    .channel_sel(q.csr.channel_sel),
    .cur(q.cur),
    .first(plan_first),
    .next(plan_next),
    .last(plan_last)
  );

  assign bank_wr = (q.st == ST_WAIT) && conv_rsp.done && q.start;

  adcrm_result_bank #(
    .CHANNELS(16)
  ) u_bank (
    .core_clk(core_clk),
    .nrst(nrst),
    .standby(standby),
    .wr_en(bank_wr),
    .wr_chan(q.cur),
    .wr_value(conv_rsp.value),
    .rd_chan(wb_adr_i[5:2]),
    .rd_data(bank_data)
  );

  // ==========================================================
  // Bus decode
  assign req = wb_cyc_i && wb_stb_i && !q.ack && !q.err;
  assign hit_res = (wb_adr_i < `ADCRM_CSR_OFS) && (wb_adr_i[1:0] == 2'h0);
  assign hit_csr = (wb_adr_i == `ADCRM_CSR_OFS);
  assign hit_ctrl = (wb_adr_i == `ADCRM_CTRL_OFS);
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.err = 1'b0;
    // Bus answer, one cycle after the request
    if (req) begin
      if (hit_res || hit_csr || hit_ctrl) begin
        next_q.ack = 1'b1;
      end else begin
        next_q.err = 1'b1;
      end
      if (!wb_we_i) begin
        if (hit_res) begin
          next_q.rdata = {16'h0000, bank_data};
        end else if (hit_csr) begin
          next_q.rdata = {24'h000000, q.csr};
        end else if (hit_ctrl) begin
          next_q.rdata = {30'h0, q.start, q.scan_cont};
        end else begin
          next_q.rdata = 32'h00000000;
        end
      end
    end
    // Remember a read that saw the flag set
    if (req && !wb_we_i && hit_csr && q.csr.conversion_end_flag) begin
      next_q.flag_seen = 1'b1;
    end
    // Software writes to control/status
    if (wr_lane0 && hit_csr) begin
      next_q.csr.conversion_irq_enable = wb_dat_i[`ADCRM_IE_BIT];
      next_q.csr.mode = adcrm_mode_t'(wb_dat_i[5:4]);
      next_q.csr.channel_sel = wb_dat_i[3:0];
      if (!wb_dat_i[`ADCRM_FLAG_BIT] && q.flag_seen) begin
        next_q.csr.conversion_end_flag = 1'b0;
        next_q.flag_seen = 1'b0;
      end
    end
    // DMA service clears the flag
    if (dma_ack && unit0_conversion_irq) begin
      next_q.csr.conversion_end_flag = 1'b0;
      next_q.flag_seen = 1'b0;
    end
    // Software writes to start and scan control
    if (wr_lane0 && hit_ctrl) begin
      next_q.start = wb_dat_i[`ADCRM_CTRL_START_BIT];
      next_q.scan_cont = wb_dat_i[`ADCRM_CTRL_SCAN_BIT];
    end
    // Sequencer
    case (q.st)
      ST_IDLE: begin
        if (q.start) begin
          next_q.cur = plan_first;
          next_q.st = ST_REQ;
        end
      end
      ST_REQ: begin
        next_q.st = q.start ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        if (!q.start) begin
          next_q.st = ST_IDLE;
        end else if (conv_rsp.done) begin
          if (plan_last) begin
            next_q.csr.conversion_end_flag = 1'b1;
            if (q.csr.mode == ADCRM_SINGLE || !q.scan_cont) begin
              next_q.start = 1'b0;
              next_q.st = ST_IDLE;
            end else begin
              next_q.cur = plan_first;
              next_q.st = ST_REQ;
            end
          end else begin
            next_q.cur = plan_next;
            next_q.st = ST_REQ;
          end
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (!nrst || standby) begin
      q.csr <= adcrm_csr_t'(`ADCRM_CSR_RESET);
      q.start <= 1'b0;
      q.scan_cont <= 1'b0;
      q.flag_seen <= 1'b0;
      q.st <= ST_IDLE;
      q.cur <= 4'h0;
      q.ack <= 1'b0;
      q.err <= 1'b0;
      q.rdata <= 32'h00000000;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = q.ack;
  assign wb_err_o = q.err;
  assign wb_dat_o = q.rdata;
  // Request pulse and channel packed in one go: one driver for the struct
  assign conv_req = {(q.st == ST_REQ) && q.start, q.cur};
  // Interrupt while flag and enable are both set
  assign unit0_conversion_irq = q.csr.conversion_end_flag && q.csr.conversion_irq_enable;

  // ==========================================================
  // Checks
  sequence s_done_last;
    (q.st == ST_WAIT) && q.start && conv_rsp.done && plan_last;
  endsequence

  property p_flag_set;
    @(posedge core_clk) disable iff (!nrst || standby)
      s_done_last |=> q.csr.conversion_end_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("end flag not set");

  // Clearing the enable must drop the request on the next cycle
  property p_irq;
    @(posedge core_clk) disable iff (!nrst || standby)
      (wr_lane0 && hit_csr && !wb_dat_i[`ADCRM_IE_BIT]) |=> !unit0_conversion_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not dropped");

  property p_dma_clear;
    @(posedge core_clk) disable iff (!nrst || standby)
      (dma_ack && unit0_conversion_irq && !bank_wr) |=> !q.csr.conversion_end_flag;
  endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("dma did not clear flag");

  property p_single_stop;
    @(posedge core_clk) disable iff (!nrst || standby)
      (s_done_last and (q.csr.mode == ADCRM_SINGLE)) |=> !q.start && q.st == ST_IDLE;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single did not stop");

  property p_oneshot_stop;
    @(posedge core_clk) disable iff (!nrst || standby)
      (s_done_last and !q.scan_cont) |=> !q.start;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("scan did not stop");

  property p_cont_go;
    @(posedge core_clk) disable iff (!nrst || standby)
      (s_done_last and q.scan_cont and (q.csr.mode != ADCRM_SINGLE)
       and !(wr_lane0 && hit_ctrl)) |=> q.start && conv_req.req;
  endproperty
  a_cont_go: assert property (p_cont_go) else $error("scan stopped");

  property p_one_set;
    @(posedge core_clk) disable iff (!nrst || standby)
      (req && wb_we_i && hit_csr && wb_sel_i[0] && wb_dat_i[7] && !q.csr.conversion_end_flag
       && !bank_wr) |=> !q.csr.conversion_end_flag;
  endproperty
  a_one_set: assert property (p_one_set) else $error("write of one set flag");

  property p_scan12_range;
    @(posedge core_clk) disable iff (!nrst || standby)
      (conv_req.req && q.csr.mode == ADCRM_SCAN12) |-> conv_req.chan < 4'hC;
  endproperty
  a_scan12_range: assert property (p_scan12_range) else $error("channel out of range");

  property p_scan8_range;
    @(posedge core_clk) disable iff (!nrst || standby)
      (conv_req.req && q.csr.mode == ADCRM_SCAN8) |-> conv_req.chan < 4'h8;
  endproperty
  a_scan8_range: assert property (p_scan8_range) else $error("channel out of range");

  property p_stop_req;
    @(posedge core_clk) disable iff (!nrst || standby)
      !q.start |-> !conv_req.req;
  endproperty
  a_stop_req: assert property (p_stop_req) else $error("request while stopped");

  property p_ack_drop;
    @(posedge core_clk) disable iff (!nrst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
endmodule // adcrm_top

// ===== src/adcrm_cfg.svh
// Constants for the converter result and mode control block.
// Assumes a Wishbone slave with byte addresses and 32-bit data lanes.
`ifndef ADCRM_CFG_SVH
`define ADCRM_CFG_SVH
`define ADCRM_RESULT_BASE 8'h00
`define ADCRM_CSR_OFS 8'h40
`define ADCRM_CTRL_OFS 8'h44
`define ADCRM_CSR_RESET 8'h00
`define ADCRM_CTRL_RESET 8'h00
`define ADCRM_FLAG_BIT 7
`define ADCRM_IE_BIT 6
`define ADCRM_MODE_LSB 4
`define ADCRM_CTRL_START_BIT 1
`define ADCRM_CTRL_SCAN_BIT 0
`endif

// ===== src/adcrm_pkg.sv
// Types shared by the converter control block.
// Assumes the constants header is included beside it.
package adcrm_pkg;
  typedef enum logic [1:0] {
    ADCRM_SINGLE = 2'h0,
    ADCRM_SCAN4 = 2'h1,
    ADCRM_SCAN8 = 2'h2,
    ADCRM_SCAN12 = 2'h3
  } adcrm_mode_t;

  typedef struct packed {
    logic conversion_end_flag;
    logic conversion_irq_enable;
    adcrm_mode_t mode;
    logic [3:0] channel_sel;
  } adcrm_csr_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } adcrm_wb_req_t;

  typedef struct packed {
    logic req;
    logic [3:0] chan;
  } adcrm_conv_req_t;

  typedef struct packed {
    logic done;
    logic [9:0] value;
  } adcrm_conv_rsp_t;
endpackage

// ===== src/adcrm_chan_plan.sv
// Channel planner: first and last channel and group stepping per mode.
// Assumes mode and channel fields are stable while a conversion runs.
`timescale 1ns/10ps
module adcrm_chan_plan (
  input wire adcrm_pkg::adcrm_mode_t mode,
  input wire logic [3:0] channel_sel,
  input wire logic [3:0] cur,
  output logic [3:0] first,
  output logic [3:0] next,
  output logic last
);
  import adcrm_pkg::*;
  logic [1:0] top_grp;
  logic [1:0] off;
  // Work out group span and position within the pass
  always_comb begin
    off = channel_sel[1:0];
    first = 4'h0;
    top_grp = 2'h0;
    case (mode)
      ADCRM_SINGLE: begin
        first = channel_sel;
        top_grp = channel_sel[3:2];
      end
      ADCRM_SCAN4: begin
        first = {channel_sel[3:2], 2'h0};
        top_grp = channel_sel[3:2];
      end
      ADCRM_SCAN8: begin
        top_grp = 2'h1;
      end
      ADCRM_SCAN12: begin
        top_grp = 2'h2;
      end
      default: begin
        top_grp = 2'h0;
      end
    endcase
    if (mode == ADCRM_SINGLE) begin
      last = 1'b1;
      next = cur;
    end else begin
      last = (cur[3:2] == top_grp) && (cur[1:0] == off);
      if (cur[1:0] == off) begin
        next = {cur[3:2] + 2'h1, 2'h0};
      end else begin
        next = cur + 4'h1;
      end
    end
  end
endmodule // adcrm_chan_plan

// ===== src/adcrm_result_bank.sv
// Sixteen result registers, one per analog input, read by index.
// Assumes writes come from the sequencer only; software cannot write.
`timescale 1ns/10ps
module adcrm_result_bank #(
  parameter int CHANNELS = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic standby,
  input wire logic wr_en,
  input wire logic [3:0] wr_chan,
  input wire logic [9:0] wr_value,
  input wire logic [3:0] rd_chan,
  output logic [15:0] rd_data
);
  import adcrm_pkg::*;
  // One entry per input so each generate branch owns its own variable
  logic [9:0] store [CHANNELS];
  // Per-channel storage, cleared by reset and standby
  genvar k;
  generate
    for (k = 0; k < CHANNELS; k++) begin : g_chan
      always_ff @(posedge core_clk) begin
        if (!nrst || standby) begin
          store[k] <= 10'h000;
        end else if (wr_en && (wr_chan == 4'(k))) begin
          store[k] <= wr_value;
        end
      end
    end
  endgenerate
  // Pack value into high byte and bits 7..6, rest zero
  assign rd_data = {store[rd_chan], 6'h00};
endmodule // adcrm_result_bank

// ===== verification/adcrm_top_tb_top.sv
// Self-checking bench for the converter result and mode control block.
// Assumes the block answers Wishbone one cycle after taking a request and
// that the bench plays the analog core and the DMA acknowledge itself.
`timescale 1ns/10ps
module adcrm_top_tb_top;
  import adcrm_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic standby = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic dma_ack = 1'b0;
  logic unit0_conversion_irq;
  adcrm_conv_req_t conv_req;
  adcrm_conv_rsp_t conv_rsp = '0;
  int error_cnt = 0;
  int total_checks = 0;
  int resp_dly = 2;
  int cnt = 0;
  int n0 = 0;
  logic pend = 1'b0;
  logic [3:0] pch = 4'h0;
  logic [3:0] reqs[$];
  logic [31:0] rd;
  logic er;

  adcrm_top adcrm_top_i (.core_clk(core_clk), .nrst(nrst), .standby(standby),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .conv_req(conv_req), .conv_rsp(conv_rsp), .dma_ack(dma_ack),
    .unit0_conversion_irq(unit0_conversion_irq));

  // ==========================================================
  // Clock and analog core stand-in
  // ==========================================================
  // Clock of 10 ns period
  always #5 core_clk = ~core_clk;

  // Distinct value per channel so a misplaced result shows
  function automatic logic [9:0] cval(input logic [3:0] c);
    return 10'h2C3 ^ {c, c, 2'h1};
  endfunction

  // Answers each request resp_dly+1 cycles after seeing it; value toggles when not valid
  always @(posedge core_clk) begin
    if (pend && cnt == 0) conv_rsp <= '{1'b1, cval(pch)};
    else conv_rsp <= '{1'b0, ~conv_rsp.value};
    if (conv_req.req === 1'b1) begin
      reqs.push_back(conv_req.chan);
      pend <= 1'b1;
      cnt <= resp_dly;
      pch <= conv_req.chan;
    end else if (pend) begin
      if (cnt == 0) pend <= 1'b0;
      else cnt <= cnt - 1;
    end
  end

  // ==========================================================
  // Bus tasks and comparisons
  // ==========================================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; holds the request until ack or err is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic e);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0, rd, er);
    check(nm, rd, exp);
  endtask

  // Expected channel order, one nibble per request, lowest nibble first
  task automatic chk_seq(input int n, input logic [63:0] e);
    for (int i = 0; i < n; i++) check("chan", {28'h0, reqs[i]}, {28'h0, e[4*i+:4]});
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (unit0_conversion_irq !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300) error_cnt++;
  endtask

  task automatic start(input logic [31:0] csr, input logic [31:0] ctrl);
    reqs.delete();
    wr(8'h40, csr);
    wr(8'h44, ctrl);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd_chk("result0", 8'h00, 32'h0);
    rd_chk("csr", 8'h40, 32'h0);
    wr(8'h14, 32'hFFFF);
    rd_chk("result5", 8'h14, 32'h0);
    wb_xfer(1'b0, 8'h80, 32'h0, rd, er);
    check("unmapped err", {31'h0, er}, 32'h1);
    $display("test reset done");
    // Single conversion on input 5
    start(32'h45, 32'h2);
    wait_irq();
    check("irq", {31'h0, unit0_conversion_irq}, 32'h1);
    repeat (10) @(posedge core_clk);
    check("req count", reqs.size(), 32'h1);
    chk_seq(1, 64'h5);
    rd_chk("result5", 8'h14, {16'h0, cval(4'h5), 6'h00});
    rd_chk("result4", 8'h10, 32'h0);
    rd_chk("ctrl", 8'h44, 32'h0);
    wr(8'h40, 32'h45);
    rd_chk("csr unarmed", 8'h40, 32'hC5);
    wr(8'h40, 32'h45);
    rd_chk("csr cleared", 8'h40, 32'h45);
    check("irq", {31'h0, unit0_conversion_irq}, 32'h0);
    wr(8'h40, 32'hC5);
    rd_chk("csr set ignored", 8'h40, 32'h45);
    $display("test single done");
    // Single-cycle twelve-channel scan, two channels per group, slow answers
    resp_dly = 6;
    start(32'h71, 32'h2);
    wait_irq();
    repeat (40) @(posedge core_clk);
    check("req count", reqs.size(), 32'h6);
    chk_seq(6, 64'h985410);
    rd_chk("result9", 8'h24, {16'h0, cval(4'h9), 6'h00});
    wr(8'h40, 32'h31);
    check("irq masked", {31'h0, unit0_conversion_irq}, 32'h0);
    wr(8'h40, 32'h71);
    check("irq", {31'h0, unit0_conversion_irq}, 32'h1);
    dma_ack <= 1'b1;
    @(posedge core_clk);
    dma_ack <= 1'b0;
    @(posedge core_clk);
    rd_chk("csr dma", 8'h40, 32'h71);
    $display("test scan12 done");
    // Continuous four-channel scan over inputs 4 to 6, then stop
    resp_dly = 1;
    wr(8'h44, 32'h0);
    start(32'h56, 32'h3);
    wait_irq();
    repeat (40) @(posedge core_clk);
    chk_seq(4, 64'h4654);
    check("keeps running", {31'h0, reqs.size() > 4}, 32'h1);
    wr(8'h44, 32'h0);
    n0 = reqs.size();
    repeat (40) @(posedge core_clk);
    check("stopped", reqs.size(), n0);
    $display("test scan4 done");
    // Single-cycle eight-channel scan with prompt answers
    resp_dly = 0;
    rd_chk("csr", 8'h40, 32'hD6);
    start(32'h63, 32'h2);
    check("irq after clear", {31'h0, unit0_conversion_irq}, 32'h0);
    wait_irq();
    repeat (30) @(posedge core_clk);
    check("req count", reqs.size(), 32'h8);
    chk_seq(8, 64'h76543210);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    @(posedge core_clk);
    rd_chk("result7", 8'h1C, 32'h0);
    rd_chk("csr", 8'h40, 32'h0);
    $display("test scan8 and standby done");
    finish_test();
  end

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
endmodule // adcrm_top_tb_top
